/* rtl/hbp_fault_protect.sv */
`timescale 1ns/100ps
module hbp_fault_protect #(
	parameter int BRIDGES  = hbp_pkg::HBP_BRIDGES,
	parameter int OC_CYC   = hbp_pkg::OC_FILTER_CYC,
	parameter int OL_CYC   = hbp_pkg::OL_FILTER_CYC,
	parameter int DEAD_CYC = hbp_pkg::DEAD_TIME_CYC
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [BRIDGES-1:0] highSideSwitchEnable,
	input  wire logic [BRIDGES-1:0] lowSideSwitchEnable,
	input  wire logic [BRIDGES-1:0] highSideOvercurrentPin,
	input  wire logic [BRIDGES-1:0] lowSideOvercurrentPin,
	input  wire logic [BRIDGES-1:0] highSideUndercurrentPin,
	input  wire logic [BRIDGES-1:0] lowSideUndercurrentPin,
	input  wire logic               tempWarnPin,
	input  wire logic               tempShutdownPin,
	input  wire logic               supplyUndervoltagePin,
	input  wire logic               supplyOvervoltagePin,
	input  wire logic               enablePin,
	input  wire logic [BRIDGES-1:0] clearHighSideOvercurrent,
	input  wire logic [BRIDGES-1:0] clearLowSideOvercurrent,
	input  wire logic [BRIDGES-1:0] clearHighSideOpenLoad,
	input  wire logic [BRIDGES-1:0] clearLowSideOpenLoad,
	input  wire logic               clearLoadError,
	input  wire logic               clearPrewarning,
	input  wire logic               clearShutdown,
	input  wire logic               clearUndervoltage,
	input  wire logic               clearOvervoltage,
	input  wire logic               clearPowerOnReset,
	output logic      [BRIDGES-1:0] highSideGate,
	output logic      [BRIDGES-1:0] lowSideGate,
	output logic      [BRIDGES-1:0] highSideOvercurrentFlag,
	output logic      [BRIDGES-1:0] lowSideOvercurrentFlag,
	output logic      [BRIDGES-1:0] highSideOpenLoadFlag,
	output logic      [BRIDGES-1:0] lowSideOpenLoadFlag,
	output logic                    loadErrorFlag,
	output logic                    thermalPrewarningFlag,
	output logic                    thermalShutdownFlag,
	output logic                    supplyUndervoltageFlag,
	output logic                    supplyOvervoltageFlag,
	output logic                    negatedPowerOnResetFlag,
	output logic                    spiResponsive
);
	import hbp_pkg::*;

	localparam int MAXC = (OC_CYC > OL_CYC) ? OC_CYC : OL_CYC;
	localparam int CW   = $clog2(MAXC + 1);
	localparam logic [CW-1:0] OC_LIM = CW'(OC_CYC);
	localparam logic [CW-1:0] OL_LIM = CW'(OL_CYC);

	typedef struct packed {
		logic [BRIDGES-1:0] ocHs;
		logic [BRIDGES-1:0] ocLs;
		logic [BRIDGES-1:0] olHs;
		logic [BRIDGES-1:0] olLs;
		logic               tw;
		logic               ts;
		logic               uv;
		logic               ov;
		logic               en;
	} hbp_pins_s;

	typedef struct packed {
		hbp_pins_s                     pin1;
		hbp_pins_s                     pin2;
		logic [BRIDGES-1:0]            hsOc;
		logic [BRIDGES-1:0]            lsOc;
		logic [BRIDGES-1:0]            hsOl;
		logic [BRIDGES-1:0]            lsOl;
		logic [2*BRIDGES-1:0][CW-1:0]  ocCnt;
		logic [2*BRIDGES-1:0][CW-1:0]  olCnt;
		logic                          loadErr;
		logic                          thermal_prewarning_flag;
		logic                          thermal_shutdown_flag;
		logic                          uv;
		logic                          ov;
		logic                          negated_power_on_reset_flag;
		logic                          spiOn;
	} hbp_state_s;

	hbp_state_s         r;
	hbp_state_s         n;
	logic [BRIDGES-1:0] hsReq;
	logic [BRIDGES-1:0] lsReq;
	logic [BRIDGES-1:0] hsOn;
	logic [BRIDGES-1:0] lsOn;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Counts up to the limit and holds there while the condition holds, restarts when it drops
	function automatic logic [CW-1:0] filterStep(
		input logic [CW-1:0] cnt,
		input logic          cond,
		input logic [CW-1:0] lim
	);
		if (!cond) begin
			return '0;
		end else if (cnt < lim) begin
			return CW'(cnt + 1'b1);
		end
		return cnt;
	endfunction : filterStep

	// Sticky flag where a set in the clearing cycle wins
	function automatic logic latchNext(
		input logic flag,
		input logic set,
		input logic clr
	);
		return set | (flag & ~clr);
	endfunction : latchNext

	////////////////////////////////////////////////////////////////////////
	// Fault latching
	always_comb begin
		n = r;
		n.pin1 = '{ocHs: highSideOvercurrentPin,
		           ocLs: lowSideOvercurrentPin,
		           olHs: highSideUndercurrentPin,
		           olLs: lowSideUndercurrentPin,
		           tw: tempWarnPin, ts: tempShutdownPin,
		           uv: supplyUndervoltagePin, ov: supplyOvervoltagePin,
		           en: enablePin};
		n.pin2 = r.pin1;
		for (int i = 0; i < BRIDGES; i++) begin
			n.ocCnt[i] = filterStep(r.ocCnt[i],
				r.pin2.ocHs[i] & hsOn[i], OC_LIM);
			n.ocCnt[BRIDGES+i] = filterStep(r.ocCnt[BRIDGES+i],
				r.pin2.ocLs[i] & lsOn[i], OC_LIM);
			n.olCnt[i] = filterStep(r.olCnt[i],
				r.pin2.olHs[i] & hsOn[i], OL_LIM);
			n.olCnt[BRIDGES+i] = filterStep(r.olCnt[BRIDGES+i],
				r.pin2.olLs[i] & lsOn[i], OL_LIM);
			n.hsOc[i] = latchNext(r.hsOc[i], n.ocCnt[i] == OC_LIM,
				clearHighSideOvercurrent[i]);
			n.lsOc[i] = latchNext(r.lsOc[i],
				n.ocCnt[BRIDGES+i] == OC_LIM,
				clearLowSideOvercurrent[i]);
			n.hsOl[i] = latchNext(r.hsOl[i], n.olCnt[i] == OL_LIM,
				clearHighSideOpenLoad[i]);
			n.lsOl[i] = latchNext(r.lsOl[i],
				n.olCnt[BRIDGES+i] == OL_LIM,
				clearLowSideOpenLoad[i]);
		end
		n.loadErr = latchNext(r.loadErr,
			|{n.hsOc, n.lsOc, n.hsOl, n.lsOl}, clearLoadError);
		n.thermal_prewarning_flag = latchNext(r.thermal_prewarning_flag, r.pin2.tw, clearPrewarning);
		n.thermal_shutdown_flag = latchNext(r.thermal_shutdown_flag, r.pin2.ts, clearShutdown);
		n.uv  = latchNext(r.uv, r.pin2.uv, clearUndervoltage);
		n.ov  = latchNext(r.ov, r.pin2.ov, clearOvervoltage);
		n.negated_power_on_reset_flag = r.negated_power_on_reset_flag | (clearPowerOnReset & r.pin2.en);
		n.spiOn = r.pin2.en;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{pin1: '0, pin2: '0,
			      hsOc: '0, lsOc: '0, hsOl: '0, lsOl: '0,
			      ocCnt: '0, olCnt: '0,
			      loadErr: FLAG_RST, thermal_prewarning_flag: FLAG_RST, thermal_shutdown_flag: FLAG_RST,
			      uv: FLAG_RST, ov: FLAG_RST,
			      negated_power_on_reset_flag: NEGATED_POWER_ON_RESET_FLAG_RST, spiOn: 1'b0};
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage gating; enable inputs are only read, never changed
	always_comb begin
		for (int i = 0; i < BRIDGES; i++) begin
			hsReq[i] = highSideSwitchEnable[i] & ~r.hsOc[i] & ~r.lsOc[i]
				& ~r.thermal_shutdown_flag & ~r.pin2.ts
				& ~r.pin2.uv & ~r.pin2.ov;
			lsReq[i] = lowSideSwitchEnable[i] & ~r.hsOc[i] & ~r.lsOc[i]
				& ~r.thermal_shutdown_flag & ~r.pin2.ts
				& ~r.pin2.uv & ~r.pin2.ov;
		end
	end

	for (genvar g = 0; g < BRIDGES; g++) begin : gBridge
		hbp_dead_time #(
			.DEAD_CYC (DEAD_CYC)
		) uDeadTime (
			.clk     (clk),
			.rst     (rst),
			.highReq (hsReq[g]),
			.lowReq  (lsReq[g]),
			.highOn  (hsOn[g]),
			.lowOn   (lsOn[g])
		);
	end

	assign highSideGate            = hsOn;
	assign lowSideGate             = lsOn;
	assign highSideOvercurrentFlag = r.hsOc;
	assign lowSideOvercurrentFlag  = r.lsOc;
	assign highSideOpenLoadFlag    = r.hsOl;
	assign lowSideOpenLoadFlag     = r.lsOl;
	assign loadErrorFlag           = r.loadErr;
	assign thermalPrewarningFlag   = r.thermal_prewarning_flag;
	assign thermalShutdownFlag     = r.thermal_shutdown_flag;
	assign supplyUndervoltageFlag  = r.uv;
	assign supplyOvervoltageFlag   = r.ov;
	assign negatedPowerOnResetFlag = r.negated_power_on_reset_flag;
	assign spiResponsive           = r.spiOn;

endmodule : hbp_fault_protect

/* shared/hbp_pkg.sv */
package hbp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_FREQ_MHZ   = 200;
	localparam int NS_PER_US      = 1000;
	localparam int OC_FILTER_NS   = 10000;
	localparam int OL_FILTER_NS   = 20000;
	localparam int DEAD_TIME_NS   = 500;

	// Least time in cycles, rounded up, never below one cycle
	function automatic int nsToCycMin(input int ns);
		int cyc;
		cyc = (ns * CLK_FREQ_MHZ + NS_PER_US - 1) / NS_PER_US;
		return (cyc < 1) ? 1 : cyc;
	endfunction : nsToCycMin

	localparam int OC_FILTER_CYC  = nsToCycMin(OC_FILTER_NS);
	localparam int OL_FILTER_CYC  = nsToCycMin(OL_FILTER_NS);
	localparam int DEAD_TIME_CYC  = nsToCycMin(DEAD_TIME_NS);

	////////////////////////////////////////////////////////////////////////
	// Structure and reset values
	localparam int   HBP_BRIDGES  = 4;
	localparam logic FLAG_RST     = 1'b0;
	localparam logic NEGATED_POWER_ON_RESET_FLAG_RST     = 1'b0;

	typedef enum logic [2:0] {
		HBP_OFF = 3'b001,
		HBP_HS  = 3'b010,
		HBP_LS  = 3'b100
	} hbp_drive_e;

endpackage : hbp_pkg

/* rtl/hbp_dead_time.sv */
`timescale 1ns/100ps
module hbp_dead_time #(
	parameter int DEAD_CYC = hbp_pkg::DEAD_TIME_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic highReq,
	input  wire logic lowReq,
	output logic      highOn,
	output logic      lowOn
);
	import hbp_pkg::*;

	localparam int DW = $clog2(DEAD_CYC + 1);
	localparam logic [DW-1:0] GAP_FULL = DW'(DEAD_CYC);

	typedef struct packed {
		hbp_drive_e      st;
		logic [DW-1:0]   gap;
		logic            hi;
		logic            lo;
	} hbp_dt_s;

	hbp_dt_s r;
	hbp_dt_s n;
	hbp_drive_e want;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = r;
		// Both requested at once means neither conducts
		if (highReq && !lowReq) begin
			want = HBP_HS;
		end else if (lowReq && !highReq) begin
			want = HBP_LS;
		end else begin
			want = HBP_OFF;
		end
		case (r.st)
			HBP_OFF: begin
				if (r.gap != GAP_FULL) begin
					n.gap = DW'(r.gap + 1'b1);
				end
				if (want != HBP_OFF && r.gap == GAP_FULL) begin
					n.st = want;
				end
			end
			HBP_HS, HBP_LS: begin
				if (want != r.st) begin
					n.st  = HBP_OFF;
					n.gap = '0;
				end
			end
			default: begin
				n.st  = HBP_OFF;
				n.gap = '0;
			end
		endcase
		n.hi = (n.st == HBP_HS);
		n.lo = (n.st == HBP_LS);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '{st: HBP_OFF, gap: GAP_FULL, hi: 1'b0, lo: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign highOn = r.hi;
	assign lowOn  = r.lo;

endmodule : hbp_dead_time

/* tb/hbp_fault_protect_props.sv */
`timescale 1ns/100ps
module hbp_fault_protect_props #(
	parameter int BRIDGES = 4
) (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic [BRIDGES-1:0] highSideGate,
	input wire logic [BRIDGES-1:0] lowSideGate,
	input wire logic [BRIDGES-1:0] highSideOvercurrentFlag,
	input wire logic [BRIDGES-1:0] lowSideOvercurrentFlag,
	input wire logic [BRIDGES-1:0] highSideOpenLoadFlag,
	input wire logic [BRIDGES-1:0] lowSideOpenLoadFlag,
	input wire logic               loadErrorFlag,
	input wire logic               thermalPrewarningFlag,
	input wire logic               thermalShutdownFlag,
	input wire logic               supplyUndervoltageFlag,
	input wire logic               supplyOvervoltageFlag,
	input wire logic               supplyUndervoltagePin,
	input wire logic               supplyOvervoltagePin,
	input wire logic               clearPrewarning,
	input wire logic               clearShutdown,
	input wire logic               clearPowerOnReset,
	input wire logic               negatedPowerOnResetFlag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [BRIDGES-1:0] ocAny;
	logic [BRIDGES-1:0] hsG;
	logic [BRIDGES-1:0] lsG;
	assign ocAny = highSideOvercurrentFlag | lowSideOvercurrentFlag;
	assign hsG = highSideGate;
	assign lsG = lowSideGate;
	a_no_cross: assert property ((hsG & lsG) == '0)
		else $error("both gates of a bridge on");
	a_dead_gap: assert property ((((hsG & ~$past(hsG))
		& ($past(lsG) | $past(lsG, 2))) | ((lsG & ~$past(lsG))
		& ($past(hsG) | $past(hsG, 2)))) == '0)
		else $error("gate on without gap");
	a_oc_gate_off: assert property (
		(ocAny & $past(ocAny) & (hsG | lsG)) == '0)
		else $error("gate on while overcurrent flagged");
	a_tsd_gates: assert property (thermalShutdownFlag &&
		$past(thermalShutdownFlag) |-> (hsG | lsG) == '0)
		else $error("gate on during thermal shutdown");
	a_le_cover: assert property (|{ocAny, highSideOpenLoadFlag,
		lowSideOpenLoadFlag} |-> loadErrorFlag)
		else $error("load error missing");
	a_tpw_hold: assert property (thermalPrewarningFlag && !clearPrewarning
		|=> thermalPrewarningFlag)
		else $error("prewarning dropped without clear");
	a_tsd_hold: assert property (thermalShutdownFlag && !clearShutdown
		|=> thermalShutdownFlag)
		else $error("shutdown dropped without clear");
	a_negated_power_on_reset_flag_cause: assert property ($rose(negatedPowerOnResetFlag)
		|-> $past(clearPowerOnReset))
		else $error("power-on flag set without clear");
	a_uv_off: assert property (supplyUndervoltagePin[*5]
		|-> supplyUndervoltageFlag && (hsG | lsG) == '0)
		else $error("undervoltage not handled");
	a_ov_off: assert property (supplyOvervoltagePin[*5]
		|-> supplyOvervoltageFlag && (hsG | lsG) == '0)
		else $error("overvoltage not handled");
endmodule : hbp_fault_protect_props

bind hbp_fault_protect hbp_fault_protect_props #(
	.BRIDGES (BRIDGES)
) u_props (
	.clk                     (clk),
	.rst                     (rst),
	.highSideGate            (highSideGate),
	.lowSideGate             (lowSideGate),
	.highSideOvercurrentFlag (highSideOvercurrentFlag),
	.lowSideOvercurrentFlag  (lowSideOvercurrentFlag),
	.highSideOpenLoadFlag    (highSideOpenLoadFlag),
	.lowSideOpenLoadFlag     (lowSideOpenLoadFlag),
	.loadErrorFlag           (loadErrorFlag),
	.thermalPrewarningFlag   (thermalPrewarningFlag),
	.thermalShutdownFlag     (thermalShutdownFlag),
	.supplyUndervoltageFlag  (supplyUndervoltageFlag),
	.supplyOvervoltageFlag   (supplyOvervoltageFlag),
	.supplyUndervoltagePin   (supplyUndervoltagePin),
	.supplyOvervoltagePin    (supplyOvervoltagePin),
	.clearPrewarning         (clearPrewarning),
	.clearShutdown           (clearShutdown),
	.clearPowerOnReset       (clearPowerOnReset),
	.negatedPowerOnResetFlag (negatedPowerOnResetFlag)
);

/* tb/hbp_mcu_model.sv */
`timescale 1ns/100ps
module hbp_mcu_model (
	input  wire logic        clk,
	output logic      [21:0] clr
);
	initial clr = '0;
	// Read-and-clear access: one strobe cycle for the selected flag
	task automatic rc(input int idx);
		@(negedge clk);
		clr[idx] = 1'b1;
		@(negedge clk);
		clr = '0;
	endtask : rc
endmodule : hbp_mcu_model

/* tb/half_bridge_fault_protection_test.sv */
`timescale 1ns/100ps
module half_bridge_fault_protection_test;
	logic [3:0] hsEn, lsEn, hsOcPin, lsOcPin, hsUcPin, lsUcPin, pins;
	logic [3:0] hsG, lsG, hsOc, lsOc, hsOl, lsOl, flg, hit;
	logic clk = 1'b0, rst = 1'b1, enPin, le, thermal_prewarning_flag, thermal_shutdown_flag, uvF, ovF, negated_power_on_reset_flag, spi;
	logic [21:0] clr;
	logic [31:0] seed = 32'h2D;
	int failures = 0, n_checks = 0;
	assign flg = {ovF, uvF, thermal_shutdown_flag, thermal_prewarning_flag};
	always #2.5 clk = ~clk;
	hbp_mcu_model mcu (.clk(clk), .clr(clr));
	hbp_fault_protect #(.OC_CYC(4), .OL_CYC(4), .DEAD_CYC(2)) dut (
		.clk(clk), .rst(rst), .highSideSwitchEnable(hsEn),
		.lowSideSwitchEnable(lsEn), .highSideOvercurrentPin(hsOcPin),
		.lowSideOvercurrentPin(lsOcPin), .highSideUndercurrentPin(hsUcPin),
		.lowSideUndercurrentPin(lsUcPin), .tempWarnPin(pins[0]),
		.tempShutdownPin(pins[1]), .supplyUndervoltagePin(pins[2]),
		.supplyOvervoltagePin(pins[3]), .enablePin(enPin),
		.clearHighSideOvercurrent(clr[3:0]),
		.clearLowSideOvercurrent(clr[7:4]),
		.clearHighSideOpenLoad(clr[11:8]), .clearLowSideOpenLoad(clr[15:12]),
		.clearLoadError(clr[16]), .clearPrewarning(clr[17]),
		.clearShutdown(clr[18]), .clearUndervoltage(clr[19]),
		.clearOvervoltage(clr[20]), .clearPowerOnReset(clr[21]),
		.highSideGate(hsG), .lowSideGate(lsG),
		.highSideOvercurrentFlag(hsOc), .lowSideOvercurrentFlag(lsOc),
		.highSideOpenLoadFlag(hsOl), .lowSideOpenLoadFlag(lsOl),
		.loadErrorFlag(le), .thermalPrewarningFlag(thermal_prewarning_flag),
		.thermalShutdownFlag(thermal_shutdown_flag), .supplyUndervoltageFlag(uvF),
		.supplyOvervoltageFlag(ovF), .negatedPowerOnResetFlag(negated_power_on_reset_flag),
		.spiResponsive(spi));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Requested switch only, a bridge asked for both sides stays off
	function automatic logic [7:0] expG(input logic [3:0] h,
		input logic [3:0] l);
		return {h & ~l, l & ~h};
	endfunction : expG
	// Puts a bridge mask on the conducting side: odd bridges run low side
	function automatic logic [7:0] side(input int b, input logic [3:0] m);
		return b[0] ? {4'h0, m} : {m, 4'h0};
	endfunction : side
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#10000;
		failures++;
		report_and_stop;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{hsEn, lsEn, hsOcPin, lsOcPin, hsUcPin, lsUcPin, pins} = '0;
		enPin = 1'b1;
		hit = 4'h0;
		w(16);
		rst = 1'b0;
		w(1);
		chk(16'({hsG, lsG, negated_power_on_reset_flag, le, flg}), 16'h0000);
		w(4);
		chk(16'(spi), 16'h0001);
		mcu.rc(21);
		w(1);
		chk(16'(negated_power_on_reset_flag), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			{lsEn, hsEn} = (i == 0) ? 8'hFF : seed[7:0];
			w(8);
			chk(16'({hsG, lsG}), 16'(expG(hsEn, lsEn)));
		end
		hsEn = 4'h5;
		lsEn = 4'hA;
		w(8);
		hsOcPin = 4'h1;
		w(12);
		chk(16'({hsG, lsG, hsOc, le}), 16'h0943);
		mcu.rc(16);
		w(2);
		chk(16'(le), 16'h0001);
		hsOcPin = 4'h0;
		mcu.rc(0);
		w(8);
		chk(16'({hsG, lsG, hsOc, le}), 16'h0B41);
		mcu.rc(16);
		w(2);
		chk(16'(le), 16'h0000);
		lsUcPin = 4'h2;
		w(12);
		chk(16'({hsG, lsG, lsOl, le}), 16'h0B45);
		lsUcPin = 4'h0;
		// Let the synchroniser drain, else the clear loses to a late set
		w(2);
		mcu.rc(13);
		mcu.rc(16);
		w(2);
		chk(16'({lsOl, le}), 16'h0000);
		// Overcurrent, then open load, on the conducting side of each bridge
		for (int b = 0; b < 4; b++) begin
			hit = 4'h1 << b;
			{hsOcPin, lsOcPin} = side(b, hit);
			w(12);
			chk(16'({hsG, lsG}), 16'(expG(4'h5 & ~hit, 4'hA & ~hit)));
			chk(16'({hsOc, lsOc, le}), 16'({side(b, hit), 1'b1}));
			{hsOcPin, lsOcPin} = 8'h00;
			w(2);
			mcu.rc(b[0] ? 4 + b : b);
			mcu.rc(16);
			w(8);
			chk(16'({hsG, lsG}), 16'h005A);
			chk(16'({hsOc, lsOc, le}), 16'h0000);
			{hsUcPin, lsUcPin} = side(b, hit);
			w(12);
			chk(16'({hsG, lsG}), 16'h005A);
			chk(16'({hsOl, lsOl, le}), 16'({side(b, hit), 1'b1}));
			{hsUcPin, lsUcPin} = 8'h00;
			w(2);
			mcu.rc(b[0] ? 12 + b : 8 + b);
			mcu.rc(16);
			w(2);
			chk(16'({hsOl, lsOl, le}), 16'h0000);
		end
		// Warning, shutdown, supply low, supply high in turn
		for (int k = 0; k < 4; k++) begin
			pins[k] = 1'b1;
			w(8);
			chk(16'({flg[k], hsG, lsG}), k == 0 ? 16'h15A : 16'h100);
			mcu.rc(17 + k);
			w(2);
			chk(16'(flg[k]), 16'h0001);
			pins[k] = 1'b0;
			w(8);
			chk(16'({flg[k], hsG, lsG}), k == 1 ? 16'h100 : 16'h15A);
			mcu.rc(17 + k);
			w(8);
			chk(16'({flg[k], hsG, lsG}), 16'h005A);
		end
		enPin = 1'b0;
		w(5);
		chk(16'(spi), 16'h0000);
		rst = 1'b1;
		w(1);
		chk(16'({hsG, lsG, negated_power_on_reset_flag, flg}), 16'h0000);
		// Second release with enable low: the power-on flag cannot be set
		rst = 1'b0;
		mcu.rc(21);
		w(4);
		chk(16'({spi, negated_power_on_reset_flag}), 16'h0000);
		chk(16'({hsG, lsG}), 16'h005A);
		enPin = 1'b1;
		w(4);
		chk(16'({spi, negated_power_on_reset_flag}), 16'h0002);
		report_and_stop;
	end
endmodule : half_bridge_fault_protection_test
